/* logic/mmtm_pkg.sv */
/*
  Constants for the queue-driven memory-mapped traffic master: register
  offsets and field positions of the controller's register file, reset
  values, queue sizes and the sequencer state type.
  Assumes a 32-bit classic Wishbone slave port with byte addresses.
*/
package mmtm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam int WB_AW = 8;
  localparam logic [7:0] R_CMD_ADDR = 8'h00;
  localparam logic [7:0] R_CMD_DATA = 8'h04;
  localparam logic [7:0] R_CMD_CTRL = 8'h08;
  localparam logic [7:0] R_CMD_INIT = 8'h0C;
  localparam logic [7:0] R_CMD_IDLE = 8'h10;
  localparam logic [7:0] R_ACTION = 8'h14;
  localparam logic [7:0] R_STATUS = 8'h18;
  localparam logic [7:0] R_RSP_ADDR = 8'h1C;
  localparam logic [7:0] R_RSP_DATA = 8'h20;
  localparam logic [7:0] R_RSP_LAT = 8'h24;
  localparam logic [7:0] R_RSP_WAIT = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_TYPE_BIT = 0;
  localparam int CTRL_BURST_LSB = 4;
  localparam int CTRL_BE_LSB = 16;
  localparam int ACT_PUSH_BIT = 0;
  localparam int ACT_POP_BIT = 1;
  localparam int ST_PEND_LSB = 0;
  localparam int ST_ISS_LSB = 8;
  localparam int ST_RSP_LSB = 16;
  localparam int ST_DONE_BIT = 24;
  localparam int CNT_W = 16;
  localparam int TS_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and encodings
  localparam logic [31:0] RST_CMD_CTRL = 32'h000F_0010;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic REQ_READ = 1'b0;
  localparam logic REQ_WRITE = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Queue sizes
  localparam int QDEPTH = 8;
  localparam int QPTR_W = 3;
  localparam int QCNT_W = 4;
  localparam int TDEPTH = 4;
  localparam int TPTR_W = 2;
  localparam int TCNT_W = 3;
  localparam int SHIFT_W = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_DRIVE, ST_GAP} mmtm_state_e;

endpackage

/* logic/mmtm_master.sv */
/*
  Queue-driven memory-mapped bus master for exercising a slave under test.
  Software fills a command descriptor over Wishbone, pushes it, the driver
  plays it out and the monitor queues read responses for software to pop.
  Assumes the slave shares mclk; its inputs are used without synchronising.
*/
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
module mmtm_master #(
  parameter int ADDR_W = 32,
  parameter int SYM_W = 8,
  parameter int NUM_SYM = 4,
  parameter int BCNT_W = 3,
  parameter bit USE_READ = 1'b1,
  parameter bit USE_WRITE = 1'b1,
  parameter bit USE_ADDR = 1'b1,
  parameter bit USE_BE = 1'b1,
  parameter bit USE_BCNT = 1'b1,
  parameter bit USE_RDATA = 1'b1,
  parameter bit USE_RDV = 1'b1,
  parameter bit USE_WDATA = 1'b1,
  parameter bit USE_WAIT = 1'b1,
  parameter bit USE_BEGIN = 1'b0,
  parameter bit USE_BBEGIN = 1'b0,
  parameter bit RST_HIGH = 1'b1,
  parameter bit WAIT_HIGH = 1'b1,
  parameter bit READ_HIGH = 1'b1,
  parameter bit WRITE_HIGH = 1'b1,
  parameter bit BE_HIGH = 1'b1,
  parameter bit RDV_HIGH = 1'b1,
  parameter bit LINEWRAP = 1'b1,
  parameter bit BOUNDARY_ONLY = 1'b1,
  parameter int MAX_PEND_READS = 1,
  parameter int FIX_RD_LAT = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [mmtm_pkg::WB_AW-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_wdata,
  output logic [31:0] wb_rdata,
  output logic wb_ack,
  output logic bm_read,
  output logic bm_write,
  output logic [ADDR_W-1:0] bm_address,
  output logic [NUM_SYM-1:0] bm_byteenable,
  output logic [BCNT_W-1:0] bm_burstcount,
  output logic [SYM_W*NUM_SYM-1:0] bm_writedata,
  output logic bm_begintransfer,
  output logic bm_beginbursttransfer,
  input wire logic bm_waitrequest,
  input wire logic [SYM_W*NUM_SYM-1:0] bm_readdata,
  input wire logic bm_readdatavalid,
  output logic ev_cmd_issued,
  output logic ev_rsp_complete,
  output logic ev_all_complete
);
  localparam int DW = SYM_W * NUM_SYM;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] span_mask(input logic [BCNT_W-1:0] bc);
    logic [ADDR_W-1:0] span;
    span = ADDR_W'(bc) * ADDR_W'(NUM_SYM);
    return span - ADDR_W'(1);
  endfunction

  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [BCNT_W-1:0] bc);
    logic [ADDR_W-1:0] inc;
    inc = a + ADDR_W'(NUM_SYM);
    if (LINEWRAP) return (a & ~span_mask(bc)) | (inc & span_mask(bc));
    return inc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset, input polarity, timestamp
  logic rst_a;
  logic wait_in;
  logic rdv_in;
  logic [mmtm_pkg::TS_W-1:0] ts_r;
  assign rst_a = (rst == RST_HIGH);
  assign wait_in = USE_WAIT && (bm_waitrequest == WAIT_HIGH);
  assign rdv_in = bm_readdatavalid == RDV_HIGH;

  always_ff @(posedge mclk) begin
    if (rst_a) ts_r <= '0;
    else ts_r <= ts_r + mmtm_pkg::TS_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, writes land on the acknowledge edge
  logic wb_ack_r;
  logic [31:0] wb_rdata_r;
  logic [31:0] rd_mux;
  logic wb_req;
  logic wb_wr;
  logic push;
  logic pop;
  assign wb_req = wb_cyc & wb_stb;
  assign wb_wr = wb_req & wb_we & wb_ack_r;
  assign wb_ack = wb_ack_r;
  assign wb_rdata = wb_rdata_r;
  assign push = wb_wr && hit(wb_adr, mmtm_pkg::R_ACTION) && wb_sel[0] &&
                wb_wdata[mmtm_pkg::ACT_PUSH_BIT];
  assign pop = wb_wr && hit(wb_adr, mmtm_pkg::R_ACTION) && wb_sel[0] &&
               wb_wdata[mmtm_pkg::ACT_POP_BIT];

  always_ff @(posedge mclk) begin
    if (rst_a) wb_ack_r <= 1'b0;
    else wb_ack_r <= wb_req & ~wb_ack_r;
  end

  always_ff @(posedge mclk) begin
    if (rst_a) wb_rdata_r <= mmtm_pkg::RST_WORD;
    else if (wb_req && !wb_ack_r && !wb_we) wb_rdata_r <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command descriptor
  logic [ADDR_W-1:0] cmd_addr_r;
  logic [31:0] cmd_data_r;
  logic [31:0] cmd_ctrl_r;
  logic [31:0] cmd_init_r;
  logic [31:0] cmd_idle_r;

  always_ff @(posedge mclk) begin
    if (rst_a) begin
      cmd_addr_r <= '0;
      cmd_data_r <= mmtm_pkg::RST_WORD;
      cmd_ctrl_r <= mmtm_pkg::RST_CMD_CTRL;
      cmd_init_r <= mmtm_pkg::RST_WORD;
      cmd_idle_r <= mmtm_pkg::RST_WORD;
    end else if (wb_wr) begin
      if (hit(wb_adr, mmtm_pkg::R_CMD_ADDR))
        cmd_addr_r <= ADDR_W'(merge(32'(cmd_addr_r), wb_wdata, wb_sel));
      if (hit(wb_adr, mmtm_pkg::R_CMD_DATA)) cmd_data_r <= merge(cmd_data_r, wb_wdata, wb_sel);
      if (hit(wb_adr, mmtm_pkg::R_CMD_CTRL)) cmd_ctrl_r <= merge(cmd_ctrl_r, wb_wdata, wb_sel);
      if (hit(wb_adr, mmtm_pkg::R_CMD_INIT)) cmd_init_r <= merge(cmd_init_r, wb_wdata, wb_sel);
      if (hit(wb_adr, mmtm_pkg::R_CMD_IDLE)) cmd_idle_r <= merge(cmd_idle_r, wb_wdata, wb_sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending command queue
  logic [ADDR_W-1:0] pq_addr [mmtm_pkg::QDEPTH];
  logic [DW-1:0] pq_data [mmtm_pkg::QDEPTH];
  logic pq_type [mmtm_pkg::QDEPTH];
  logic [NUM_SYM-1:0] pq_be [mmtm_pkg::QDEPTH];
  logic [BCNT_W-1:0] pq_burst [mmtm_pkg::QDEPTH];
  logic [mmtm_pkg::CNT_W-1:0] pq_init [mmtm_pkg::QDEPTH];
  logic [mmtm_pkg::CNT_W-1:0] pq_idle [mmtm_pkg::QDEPTH];
  logic [mmtm_pkg::QPTR_W-1:0] pq_wp_r;
  logic [mmtm_pkg::QPTR_W-1:0] pq_rp_r;
  logic [mmtm_pkg::QCNT_W-1:0] pq_cnt_r;
  logic pq_push;
  logic take;
  // A push into a full queue is dropped
  assign pq_push = push && (pq_cnt_r != mmtm_pkg::QCNT_W'(mmtm_pkg::QDEPTH));

  always_ff @(posedge mclk) begin
    if (pq_push) begin
      pq_addr[pq_wp_r] <= cmd_addr_r;
      pq_data[pq_wp_r] <= DW'(cmd_data_r);
      pq_type[pq_wp_r] <= cmd_ctrl_r[mmtm_pkg::CTRL_TYPE_BIT];
      pq_be[pq_wp_r] <= cmd_ctrl_r[mmtm_pkg::CTRL_BE_LSB +: NUM_SYM];
      pq_burst[pq_wp_r] <= cmd_ctrl_r[mmtm_pkg::CTRL_BURST_LSB +: BCNT_W];
      pq_init[pq_wp_r] <= cmd_init_r[mmtm_pkg::CNT_W-1:0];
      pq_idle[pq_wp_r] <= cmd_idle_r[mmtm_pkg::CNT_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_a) begin
      pq_wp_r <= '0;
      pq_rp_r <= '0;
      pq_cnt_r <= '0;
    end else begin
      if (pq_push) pq_wp_r <= pq_wp_r + mmtm_pkg::QPTR_W'(1);
      if (take) pq_rp_r <= pq_rp_r + mmtm_pkg::QPTR_W'(1);
      pq_cnt_r <= pq_cnt_r + mmtm_pkg::QCNT_W'(pq_push) - mmtm_pkg::QCNT_W'(take);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver sequencer
  mmtm_pkg::mmtm_state_e state_r;
  logic [ADDR_W-1:0] cur_addr_r;
  logic [DW-1:0] cur_data_r;
  logic cur_type_r;
  logic [NUM_SYM-1:0] cur_be_r;
  logic [BCNT_W-1:0] cur_burst_r;
  logic [mmtm_pkg::CNT_W-1:0] cur_idle_r;
  logic [mmtm_pkg::CNT_W-1:0] cnt_r;
  logic [mmtm_pkg::CNT_W-1:0] wait_cnt_r;
  logic [BCNT_W-1:0] word_left_r;
  logic first_r;
  logic first_word_r;
  logic drv;
  logic acc;
  logic last_word;
  logic [mmtm_pkg::TCNT_W-1:0] trk_cnt_r;
  logic [BCNT_W-1:0] hd_burst;
  logic [ADDR_W-1:0] hd_addr;

  assign hd_burst = (pq_burst[pq_rp_r] == '0) ? BCNT_W'(1) : pq_burst[pq_rp_r];
  assign hd_addr = BOUNDARY_ONLY ? (pq_addr[pq_rp_r] & ~span_mask(hd_burst))
                                 : pq_addr[pq_rp_r];
  // Reads wait here until the slave has room for another outstanding read
  assign take = (state_r == mmtm_pkg::ST_IDLE) && (pq_cnt_r != '0) &&
                (pq_type[pq_rp_r] == mmtm_pkg::REQ_WRITE ||
                 trk_cnt_r < mmtm_pkg::TCNT_W'(MAX_PEND_READS));
  assign drv = state_r == mmtm_pkg::ST_DRIVE;
  assign acc = drv && !wait_in;
  // A read burst is one command; a write burst is one transfer per word
  assign last_word = (cur_type_r == mmtm_pkg::REQ_READ) || (word_left_r == BCNT_W'(1));

  always_ff @(posedge mclk) begin
    if (rst_a) begin
      state_r <= mmtm_pkg::ST_IDLE;
      cur_addr_r <= '0;
      cur_data_r <= '0;
      cur_type_r <= mmtm_pkg::REQ_READ;
      cur_be_r <= '0;
      cur_burst_r <= '0;
      cur_idle_r <= '0;
      cnt_r <= '0;
      wait_cnt_r <= '0;
      word_left_r <= '0;
      first_r <= 1'b0;
      first_word_r <= 1'b0;
    end else begin
      case (state_r)
        mmtm_pkg::ST_IDLE: begin
          if (take) begin
            cur_addr_r <= hd_addr;
            cur_data_r <= pq_data[pq_rp_r];
            cur_type_r <= pq_type[pq_rp_r];
            cur_be_r <= pq_be[pq_rp_r];
            cur_burst_r <= hd_burst;
            cur_idle_r <= pq_idle[pq_rp_r];
            word_left_r <= hd_burst;
            wait_cnt_r <= '0;
            first_word_r <= 1'b1;
            cnt_r <= pq_init[pq_rp_r];
            if (pq_init[pq_rp_r] == '0) begin
              state_r <= mmtm_pkg::ST_DRIVE;
              first_r <= 1'b1;
            end else begin
              state_r <= mmtm_pkg::ST_INIT;
            end
          end
        end
        mmtm_pkg::ST_INIT: begin
          cnt_r <= cnt_r - mmtm_pkg::CNT_W'(1);
          if (cnt_r == mmtm_pkg::CNT_W'(1)) begin
            state_r <= mmtm_pkg::ST_DRIVE;
            first_r <= 1'b1;
          end
        end
        mmtm_pkg::ST_DRIVE: begin
          first_r <= 1'b0;
          if (wait_in) begin
            wait_cnt_r <= wait_cnt_r + mmtm_pkg::CNT_W'(1);
          end else begin
            first_word_r <= 1'b0;
            word_left_r <= last_word ? '0 : word_left_r - BCNT_W'(1);
            cnt_r <= cur_idle_r;
            if (!last_word) cur_addr_r <= next_addr(cur_addr_r, cur_burst_r);
            if (cur_idle_r != '0) begin
              state_r <= mmtm_pkg::ST_GAP;
            end else if (!last_word) begin
              first_r <= 1'b1;
              wait_cnt_r <= '0;
            end else begin
              state_r <= mmtm_pkg::ST_IDLE;
            end
          end
        end
        mmtm_pkg::ST_GAP: begin
          cnt_r <= cnt_r - mmtm_pkg::CNT_W'(1);
          if (cnt_r == mmtm_pkg::CNT_W'(1)) begin
            if (word_left_r != '0) begin
              state_r <= mmtm_pkg::ST_DRIVE;
              first_r <= 1'b1;
              wait_cnt_r <= '0;
            end else begin
              state_r <= mmtm_pkg::ST_IDLE;
            end
          end
        end
        default: state_r <= mmtm_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus pins; left-out ports sit at their inactive level
  assign bm_read = (USE_READ && drv && cur_type_r == mmtm_pkg::REQ_READ) ~^ READ_HIGH;
  assign bm_write = (USE_WRITE && drv && cur_type_r == mmtm_pkg::REQ_WRITE) ~^ WRITE_HIGH;
  assign bm_address = USE_ADDR ? cur_addr_r : '0;
  assign bm_byteenable = USE_BE ? (cur_be_r ~^ {NUM_SYM{BE_HIGH}}) : {NUM_SYM{~BE_HIGH}};
  assign bm_burstcount = USE_BCNT ? cur_burst_r : '0;
  assign bm_writedata = USE_WDATA ? cur_data_r : '0;
  assign bm_begintransfer = USE_BEGIN && drv && first_r;
  assign bm_beginbursttransfer = USE_BBEGIN && drv && first_r && first_word_r;
  assign ev_cmd_issued = drv && first_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read tracker: accepted reads waiting for data
  logic [ADDR_W-1:0] trk_addr [mmtm_pkg::TDEPTH];
  logic [BCNT_W-1:0] trk_burst [mmtm_pkg::TDEPTH];
  logic [mmtm_pkg::TS_W-1:0] trk_ts [mmtm_pkg::TDEPTH];
  logic [mmtm_pkg::CNT_W-1:0] trk_wait [mmtm_pkg::TDEPTH];
  logic [mmtm_pkg::TPTR_W-1:0] trk_wp_r;
  logic [mmtm_pkg::TPTR_W-1:0] trk_rp_r;
  logic [BCNT_W-1:0] mon_idx_r;
  logic [ADDR_W-1:0] mon_addr_r;
  logic [ADDR_W-1:0] mon_cur;
  logic [mmtm_pkg::SHIFT_W-1:0] lat_sh_r;
  logic rd_acc;
  logic cap;
  logic rd_done;
  assign rd_acc = acc && cur_type_r == mmtm_pkg::REQ_READ;
  // Fixed-latency mode expects single-word reads
  assign cap = (USE_RDV ? rdv_in : lat_sh_r[FIX_RD_LAT-1]) && (trk_cnt_r != '0);
  assign rd_done = cap && (mon_idx_r + BCNT_W'(1) == trk_burst[trk_rp_r]);
  assign mon_cur = (mon_idx_r == '0) ? trk_addr[trk_rp_r] : mon_addr_r;

  always_ff @(posedge mclk) begin
    if (rd_acc) begin
      trk_addr[trk_wp_r] <= cur_addr_r;
      trk_burst[trk_wp_r] <= cur_burst_r;
      trk_ts[trk_wp_r] <= ts_r;
      trk_wait[trk_wp_r] <= wait_cnt_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_a) begin
      trk_wp_r <= '0;
      trk_rp_r <= '0;
      trk_cnt_r <= '0;
      mon_idx_r <= '0;
      mon_addr_r <= '0;
      lat_sh_r <= '0;
    end else begin
      lat_sh_r <= {lat_sh_r[mmtm_pkg::SHIFT_W-2:0], rd_acc};
      if (rd_acc) trk_wp_r <= trk_wp_r + mmtm_pkg::TPTR_W'(1);
      if (rd_done) trk_rp_r <= trk_rp_r + mmtm_pkg::TPTR_W'(1);
      trk_cnt_r <= trk_cnt_r + mmtm_pkg::TCNT_W'(rd_acc) - mmtm_pkg::TCNT_W'(rd_done);
      if (cap) begin
        mon_idx_r <= rd_done ? '0 : mon_idx_r + BCNT_W'(1);
        mon_addr_r <= next_addr(mon_cur, trk_burst[trk_rp_r]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response queue and popped response
  logic [ADDR_W-1:0] rq_addr [mmtm_pkg::QDEPTH];
  logic [DW-1:0] rq_data [mmtm_pkg::QDEPTH];
  logic [mmtm_pkg::TS_W-1:0] rq_lat [mmtm_pkg::QDEPTH];
  logic [mmtm_pkg::CNT_W-1:0] rq_wait [mmtm_pkg::QDEPTH];
  logic [mmtm_pkg::QPTR_W-1:0] rq_wp_r;
  logic [mmtm_pkg::QPTR_W-1:0] rq_rp_r;
  logic [mmtm_pkg::QCNT_W-1:0] rq_cnt_r;
  logic [ADDR_W-1:0] pop_addr_r;
  logic [DW-1:0] pop_data_r;
  logic [mmtm_pkg::TS_W-1:0] pop_lat_r;
  logic [mmtm_pkg::CNT_W-1:0] pop_wait_r;
  logic ev_rsp_r;
  logic rq_push;
  logic rq_pop;
  // A full response queue loses the new word rather than stall the slave
  assign rq_push = cap && (rq_cnt_r != mmtm_pkg::QCNT_W'(mmtm_pkg::QDEPTH));
  assign rq_pop = pop && (rq_cnt_r != '0);
  assign ev_rsp_complete = ev_rsp_r;

  always_ff @(posedge mclk) begin
    if (rq_push) begin
      rq_addr[rq_wp_r] <= mon_cur;
      rq_data[rq_wp_r] <= USE_RDATA ? bm_readdata : '0;
      rq_lat[rq_wp_r] <= ts_r - trk_ts[trk_rp_r];
      rq_wait[rq_wp_r] <= trk_wait[trk_rp_r];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_a) begin
      rq_wp_r <= '0;
      rq_rp_r <= '0;
      rq_cnt_r <= '0;
      ev_rsp_r <= 1'b0;
    end else begin
      if (rq_push) rq_wp_r <= rq_wp_r + mmtm_pkg::QPTR_W'(1);
      if (rq_pop) rq_rp_r <= rq_rp_r + mmtm_pkg::QPTR_W'(1);
      rq_cnt_r <= rq_cnt_r + mmtm_pkg::QCNT_W'(rq_push) - mmtm_pkg::QCNT_W'(rq_pop);
      ev_rsp_r <= cap;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_a) begin
      pop_addr_r <= '0;
      pop_data_r <= '0;
      pop_lat_r <= '0;
      pop_wait_r <= '0;
    end else if (rq_pop) begin
      pop_addr_r <= rq_addr[rq_rp_r];
      pop_data_r <= rq_data[rq_rp_r];
      pop_lat_r <= rq_lat[rq_rp_r];
      pop_wait_r <= rq_wait[rq_rp_r];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Issued count and completion
  logic [mmtm_pkg::QCNT_W-1:0] iss_cnt_r;
  logic all_done;
  logic done_q_r;
  logic iss_inc;
  logic iss_dec;
  assign iss_inc = ev_cmd_issued && first_word_r;
  assign iss_dec = rd_done || (acc && cur_type_r == mmtm_pkg::REQ_WRITE && last_word);
  assign all_done = (pq_cnt_r == '0) && (iss_cnt_r == '0) && !iss_inc &&
                    (state_r == mmtm_pkg::ST_IDLE || state_r == mmtm_pkg::ST_GAP);
  assign ev_all_complete = all_done && !done_q_r;

  always_ff @(posedge mclk) begin
    if (rst_a) begin
      iss_cnt_r <= '0;
      done_q_r <= 1'b1;
    end else begin
      iss_cnt_r <= iss_cnt_r + mmtm_pkg::QCNT_W'(iss_inc) - mmtm_pkg::QCNT_W'(iss_dec);
      done_q_r <= all_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = mmtm_pkg::RST_WORD;
    if (hit(wb_adr, mmtm_pkg::R_CMD_ADDR)) rd_mux = 32'(cmd_addr_r);
    if (hit(wb_adr, mmtm_pkg::R_CMD_DATA)) rd_mux = cmd_data_r;
    if (hit(wb_adr, mmtm_pkg::R_CMD_CTRL)) rd_mux = cmd_ctrl_r;
    if (hit(wb_adr, mmtm_pkg::R_CMD_INIT)) rd_mux = cmd_init_r;
    if (hit(wb_adr, mmtm_pkg::R_CMD_IDLE)) rd_mux = cmd_idle_r;
    if (hit(wb_adr, mmtm_pkg::R_STATUS)) begin
      rd_mux[mmtm_pkg::ST_PEND_LSB +: 8] = 8'(pq_cnt_r);
      rd_mux[mmtm_pkg::ST_ISS_LSB +: 8] = 8'(iss_cnt_r);
      rd_mux[mmtm_pkg::ST_RSP_LSB +: 8] = 8'(rq_cnt_r);
      rd_mux[mmtm_pkg::ST_DONE_BIT] = all_done;
    end
    if (hit(wb_adr, mmtm_pkg::R_RSP_ADDR)) rd_mux = 32'(pop_addr_r);
    if (hit(wb_adr, mmtm_pkg::R_RSP_DATA)) rd_mux = 32'(pop_data_r);
    if (hit(wb_adr, mmtm_pkg::R_RSP_LAT)) rd_mux = 32'(pop_lat_r);
    if (hit(wb_adr, mmtm_pkg::R_RSP_WAIT)) rd_mux = 32'(pop_wait_r);
  end

endmodule

/* bench/mmtm_slave_model.sv */
/* Slave model for the traffic master: stalls each word, answers reads.
   Assumes default polarities, single-word reads and a shared mclk. */
module mmtm_slave_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bm_read,
  input wire logic bm_write,
  input wire logic [31:0] bm_writedata,
  input wire logic [3:0] stall,
  output logic bm_waitrequest,
  output logic bm_readdatavalid,
  output logic [31:0] bm_readdata
);
  timeunit 1ns / 1ps;
  logic [3:0] cnt_r;
  logic [31:0] mem_r;
  // Every word waits stall cycles, burst words too
  assign bm_waitrequest = (bm_read | bm_write) && cnt_r < stall;
  // Idle data is inverted so a late capture cannot pass
  assign bm_readdata = bm_readdatavalid ? mem_r : ~mem_r;
  always_ff @(posedge mclk) begin
    cnt_r <= (rst || !bm_waitrequest) ? 4'h0 : cnt_r + 4'h1;
    bm_readdatavalid <= !rst && bm_read && !bm_waitrequest;
    if (bm_write && !bm_waitrequest)
      mem_r <= bm_writedata;
  end
endmodule

/* bench/mmtm_master_monitor.sv */
/* Port checker for mmtm_master.
   Assumes default polarities and a slave that answers single-word reads. */
module mmtm_master_monitor #(parameter int ADDR_W = 32) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  input wire logic bm_read,
  input wire logic bm_write,
  input wire logic [ADDR_W-1:0] bm_address,
  input wire logic bm_waitrequest,
  input wire logic bm_readdatavalid,
  input wire logic ev_cmd_issued,
  input wire logic ev_rsp_complete,
  input wire logic ev_all_complete
);
  timeunit 1ns / 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [2:0] rd_out_r;
  // Reads accepted and not yet answered; the slave answers single words
  always_ff @(posedge mclk) begin
    if (rst) rd_out_r <= 3'h0;
    else rd_out_r <= rd_out_r + 3'(bm_read && !bm_waitrequest) - 3'(bm_readdatavalid);
  end
  wr_hold_a: assert property (bm_write && bm_waitrequest |=>
    bm_write && $stable(bm_address)) else $error("write dropped");
  rd_hold_a: assert property (bm_read && bm_waitrequest |=>
    bm_read && $stable(bm_address)) else $error("read dropped");
  ack_time_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack) else $error("ack late");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack) else $error("ack long");
  issue_ev_a: assert property ($rose(bm_read || bm_write) |-> ev_cmd_issued)
    else $error("no issue");
  rsp_ev_a: assert property (bm_readdatavalid |=> ev_rsp_complete) else $error("no rsp");
  rd_limit_a: assert property (bm_read |-> rd_out_r == 3'h0)
    else $error("too many reads");
  rst_quiet_a: assert property (disable iff (1'h0) rst |=>
    !bm_read && !bm_write && !wb_ack) else $error("busy in reset");
  done_idle_a: assert property (ev_all_complete |-> !bm_read && !bm_write)
    else $error("busy");
  cover property (bm_write && bm_waitrequest ##1 !bm_waitrequest);
  cover property (ev_rsp_complete);
  cover property (ev_all_complete);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind mmtm_master mmtm_master_monitor #(.ADDR_W(ADDR_W)) i_mmtm_master_monitor (.mclk(mclk),
  .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack), .bm_read(bm_read),
  .bm_write(bm_write), .bm_address(bm_address), .bm_waitrequest(bm_waitrequest),
  .bm_readdatavalid(bm_readdatavalid), .ev_cmd_issued(ev_cmd_issued),
  .ev_rsp_complete(ev_rsp_complete), .ev_all_complete(ev_all_complete));

/* bench/mmtm_master_test.sv */
/* Bench for mmtm_master against the stalling slave model.
   Assumes default parameters and the register map of mmtm_pkg. */
module mmtm_master_test;
  timeunit 1ns / 1ps;
  logic mclk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic ack, rd, wr, wt, rv, iss, all, rsp, bt, bbt;
  logic [3:0] be;
  logic [2:0] bc;
  logic [7:0] adr = 8'h0;
  logic [3:0] stall = 4'h0;
  logic [31:0] wd = 32'h0, q, rdat, a, wdo, rdi;
  int failures = 0, n_tests = 0, n_all = 0, n_rsp = 0, lat[2];
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    n_all += (all === 1'h1);
    n_rsp += (rsp === 1'h1);
    if (iss === 1'h1) begin
      check("byte enables", 32'(be), 32'hF);
      check("begin strobes", 32'({bt, bbt}), 32'h0);
    end
  end
  mmtm_slave_model i_mmtm_slave_model (.mclk(mclk), .rst(rst), .bm_read(rd), .bm_write(wr),
    .bm_writedata(wdo), .stall(stall), .bm_waitrequest(wt), .bm_readdatavalid(rv),
    .bm_readdata(rdi));
  mmtm_master i_mmtm_master (.mclk(mclk), .rst(rst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
    .wb_adr(adr), .wb_sel(4'hF), .wb_wdata(wd), .wb_rdata(rdat), .wb_ack(ack), .bm_read(rd),
    .bm_write(wr), .bm_address(a), .bm_byteenable(be), .bm_burstcount(bc), .bm_writedata(wdo),
    .bm_begintransfer(bt), .bm_beginbursttransfer(bbt), .bm_waitrequest(wt), .bm_readdata(rdi),
    .bm_readdatavalid(rv), .ev_cmd_issued(iss), .ev_rsp_complete(rsp), .ev_all_complete(all));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    failures += (seen !== exp);
    if (seen !== exp) $display("mismatch %s expected %h seen %h", nm, exp, seen);
  endtask
  task test_done;
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Request holds until the edge that samples ack, then drops for a cycle
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, wd} <= {2'h3, w, ad, d};
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'h1 && k < 20);
    q = rdat;
    {cyc, stb} <= 2'h0;
    if (k >= 20) begin
      failures++;
      test_done;
    end
  endtask
  task rdc(input logic [7:0] ad, input logic [31:0] e, input string nm);
    wb(1'h0, ad, 32'h0);
    check(nm, q, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'h0;
    rdc(mmtm_pkg::R_STATUS, 32'h0100_0000, "status");
    rdc(mmtm_pkg::R_CMD_CTRL, mmtm_pkg::RST_CMD_CTRL, "ctrl");
    rdc(8'h3C, 32'h0, "unmapped");
    wb(1'h1, mmtm_pkg::R_CMD_ADDR, 32'h40);
    wb(1'h1, mmtm_pkg::R_CMD_DATA, 32'hA5C3_5A3C);
    wb(1'h1, mmtm_pkg::R_CMD_CTRL, 32'h000F_0011);
    stall <= 4'h2;
    // Same write twice: only the start latency differs
    for (int i = 0; i < 2; i++) begin
      wb(1'h1, mmtm_pkg::R_CMD_INIT, 32'(3 * i));
      wb(1'h1, mmtm_pkg::R_ACTION, 32'h1);
      lat[i] = 0;
      while (iss !== 1'h1 && lat[i] < 99) begin
        @(posedge mclk);
        lat[i]++;
      end
    end
    check("init", 32'(lat[1] - lat[0]), 32'h3);
    stall <= 4'h3;
    wb(1'h1, mmtm_pkg::R_CMD_CTRL, 32'h000F_0010);
    wb(1'h1, mmtm_pkg::R_ACTION, 32'h1);
    for (int k = 0; k < 30 && q !== 32'h0101_0000; k++) wb(1'h0, mmtm_pkg::R_STATUS, 32'h0);
    check("status rsp", q, 32'h0101_0000);
    wb(1'h1, mmtm_pkg::R_ACTION, 32'h2);
    rdc(mmtm_pkg::R_RSP_ADDR, 32'h40, "rsp addr");
    rdc(mmtm_pkg::R_RSP_DATA, 32'hA5C3_5A3C, "rsp data");
    rdc(mmtm_pkg::R_RSP_WAIT, 32'h3, "rsp wait");
    rdc(mmtm_pkg::R_RSP_LAT, 32'h1, "rsp lat");
    rdc(mmtm_pkg::R_STATUS, 32'h0100_0000, "status end");
    // Two-word write burst from a misaligned start, two idle cycles per word
    wb(1'h1, mmtm_pkg::R_CMD_ADDR, 32'h4C);
    wb(1'h1, mmtm_pkg::R_CMD_INIT, 32'h0);
    wb(1'h1, mmtm_pkg::R_CMD_IDLE, 32'h2);
    wb(1'h1, mmtm_pkg::R_CMD_CTRL, 32'h000F_0021);
    wb(1'h1, mmtm_pkg::R_ACTION, 32'h1);
    for (int i = 0; i < 2; i++) begin
      lat[i] = 0;
      do begin
        @(posedge mclk);
        lat[i]++;
      end while (iss !== 1'h1 && lat[i] < 99);
      check("burst addr", a, 32'h48 + 32'(4 * i));
    end
    check("burst len", 32'(bc), 32'h2);
    // Three stall cycles, the accepting edge, then two idle cycles
    check("idle gap", 32'(lat[1]), 32'h6);
    check("rsp event", 32'(n_rsp), 32'h1);
    check("done event", 32'(n_all != 0), 32'h1);
    test_done;
  end
endmodule
